// >>> core/cmf_pkg.sv
// constants for the can message fifo control and status block
package cmf_pkg;
	// ------------------------------------------------------------
	// geometry
	// ------------------------------------------------------------
	localparam int NUM_FIFOS = 16;
	localparam int FIFO_IDX_W = 4;
	localparam int PTR_W = 5;
	localparam int CNT_W = 6;
	localparam int ADDR_W = 12;
	localparam int MSG_SHIFT = 4;
	localparam int REGION_SHIFT = 9;
	localparam int REGION_POS = 8;
	localparam int REG_POS = 2;
	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_BASE_ADDR = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_MODE = 12'h004;
	localparam logic [3:0] FIFO_REGION = 4'h1;
	localparam logic [1:0] SUB_CONTROL = 2'h0;
	localparam logic [1:0] SUB_INT = 2'h1;
	localparam logic [1:0] SUB_USER_ADDR = 2'h2;
	localparam logic [1:0] SUB_BUS_INDEX = 2'h3;
	// ------------------------------------------------------------
	// control register fields
	// ------------------------------------------------------------
	localparam int CTL_SIZE_LSB = 16;
	localparam int CTL_RESET = 14;
	localparam int CTL_INC = 13;
	localparam int CTL_DIR = 7;
	localparam int CTL_ABORTED = 6;
	localparam int CTL_LOST_ARB = 5;
	localparam int CTL_BUS_ERR = 4;
	localparam int CTL_SEND_REQ = 3;
	localparam int CTL_RTR_EN = 2;
	localparam int CTL_PRIO_LSB = 0;
	// ------------------------------------------------------------
	// interrupt register fields
	// ------------------------------------------------------------
	localparam int INT_TX_IE_LSB = 24;
	localparam int INT_RX_IE_LSB = 16;
	localparam int INT_TX_IF_LSB = 8;
	localparam int INT_RX_IF_LSB = 0;
	localparam int INT_OVF_BIT = 3;
	// ------------------------------------------------------------
	// mode register and reset values
	// ------------------------------------------------------------
	localparam logic [2:0] MODE_CONFIG = 3'h4;
	localparam logic [2:0] MODE_RESET = 3'h4;
	localparam logic [31:0] BASE_RESET = 32'h0000_0000;
	localparam logic [4:0] SIZE_RESET = 5'h00;
	localparam logic [1:0] PRIO_LOWEST = 2'h0;
	localparam logic [1:0] PRIO_HIGHEST = 2'h3;
endpackage

// >>> core/cmf_fifo_status.sv
// control and status logic for sixteen can message fifos behind apb
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module cmf_fifo_status (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [cmf_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// protocol engine events, all for the fifo named by eng_fifo_sel
	input wire logic [cmf_pkg::FIFO_IDX_W-1:0] eng_fifo_sel,
	input wire logic eng_tx_done,
	input wire logic eng_tx_aborted,
	input wire logic eng_lost_arb,
	input wire logic eng_bus_err,
	input wire logic eng_rx_store,
	input wire logic eng_rtr_rx,
	// protocol engine view of the selected fifo
	output logic [cmf_pkg::PTR_W-1:0] eng_msg_index,
	output logic [1:0] eng_priority,
	output logic [31:0] eng_msg_addr,
	// per fifo requests
	output logic [cmf_pkg::NUM_FIFOS-1:0] tx_request,
	output logic [cmf_pkg::NUM_FIFOS-1:0] abort_request,
	output logic [cmf_pkg::NUM_FIFOS-1:0] fifo_irq
);
	localparam int N = cmf_pkg::NUM_FIFOS;

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------
	function automatic logic [cmf_pkg::PTR_W-1:0] next_ptr(
		input logic [cmf_pkg::PTR_W-1:0] ptr, input logic [4:0] size);
		next_ptr = (ptr == size) ? '0 : ptr + 5'h01;
	endfunction

	function automatic logic [31:0] slot_addr(input logic [31:0] base,
		input logic [3:0] idx, input logic [cmf_pkg::PTR_W-1:0] ptr);
		logic [31:0] ofs;
		ofs = (32'({idx}) << cmf_pkg::REGION_SHIFT) + (32'({ptr}) << cmf_pkg::MSG_SHIFT);
		slot_addr = {base[31:2] + ofs[31:2], 2'b00};
	endfunction

	// order: tx not-full, tx half, tx empty, rx ovf, rx full, rx half, rx not-empty
	function automatic logic [6:0] level_flags(input logic [cmf_pkg::CNT_W-1:0] cnt,
		input logic [4:0] size, input logic dir, input logic ovf);
		logic [cmf_pkg::CNT_W-1:0] depth;
		logic [cmf_pkg::CNT_W:0] twice;
		logic full;
		depth = {1'b0, size} + 6'h01;
		twice = {cnt, 1'b0};
		full = (cnt == depth);
		level_flags[6] = dir & ~full;
		level_flags[5] = dir & (twice <= {1'b0, depth});
		level_flags[4] = dir & (cnt == 6'h00);
		level_flags[3] = ~dir & ovf;
		level_flags[2] = ~dir & full;
		level_flags[1] = ~dir & (twice >= {1'b0, depth});
		level_flags[0] = ~dir & (cnt != 6'h00);
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [31:0] base_addr;
	logic [2:0] operating_mode_select;
	logic [4:0] fifo_size [N];
	logic [N-1:0] direction_select;
	logic [N-1:0] auto_remote_reply_enable;
	logic [1:0] transmit_priority [N];
	logic [N-1:0] send_request;
	logic [N-1:0] abort_pend;
	logic [N-1:0] msg_aborted_flag;
	logic [N-1:0] lost_arbitration_flag;
	logic [N-1:0] transmit_bus_error_flag;
	logic [N-1:0] rx_overflow_flag;
	logic [6:0] irq_enable [N];
	logic [cmf_pkg::PTR_W-1:0] head [N];
	logic [cmf_pkg::PTR_W-1:0] tail [N];
	logic [cmf_pkg::CNT_W-1:0] count [N];

	// ------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------
	logic setup_rd;
	logic access_wr;
	logic in_region;
	logic [3:0] acc_fifo;
	logic [1:0] acc_sub;
	logic mapped;
	logic config_mode;

	assign setup_rd = psel & ~penable & ~pwrite;
	assign access_wr = psel & penable & pwrite & (paddr[1:0] == 2'b00);
	assign in_region = (paddr[cmf_pkg::ADDR_W-1:cmf_pkg::REGION_POS] == cmf_pkg::FIFO_REGION);
	assign acc_fifo = paddr[7:4];
	assign acc_sub = paddr[3:2];
	assign mapped = in_region | (paddr == cmf_pkg::OFS_BASE_ADDR) | (paddr == cmf_pkg::OFS_MODE);
	assign config_mode = (operating_mode_select == cmf_pkg::MODE_CONFIG);
	assign pready = 1'b1;
	assign pslverr = psel & penable & (~mapped | (paddr[1:0] != 2'b00));

	logic [N-1:0] wr_ctrl;
	logic [N-1:0] wr_int;
	logic [N-1:0] rd_ctrl;
	logic [N-1:0] fifo_rst;
	logic [N-1:0] user_inc;
	logic [N-1:0] hit;
	logic [N-1:0] push;
	logic [N-1:0] pop;
	logic [N-1:0] last_sent;
	logic [6:0] flags [N];

	always_comb begin
		for (int i = 0; i < N; i++) begin
			hit[i] = (eng_fifo_sel == 4'(i));
			wr_ctrl[i] = access_wr & in_region & (acc_fifo == 4'(i)) & (acc_sub == cmf_pkg::SUB_CONTROL);
			wr_int[i] = access_wr & in_region & (acc_fifo == 4'(i)) & (acc_sub == cmf_pkg::SUB_INT);
			rd_ctrl[i] = setup_rd & in_region & (acc_fifo == 4'(i)) & (acc_sub == cmf_pkg::SUB_CONTROL);
			fifo_rst[i] = wr_ctrl[i] & pwdata[cmf_pkg::CTL_RESET];
			user_inc[i] = wr_ctrl[i] & pwdata[cmf_pkg::CTL_INC];
			flags[i] = level_flags(count[i], fifo_size[i], direction_select[i], rx_overflow_flag[i]);
			// transmit: software pushes, engine pops; receive the other way round
			if (direction_select[i]) begin
				push[i] = user_inc[i] & flags[i][6];
				pop[i] = hit[i] & eng_tx_done & ~flags[i][4];
			end else begin
				push[i] = hit[i] & eng_rx_store & ~flags[i][2];
				pop[i] = user_inc[i] & flags[i][0];
			end
			last_sent[i] = pop[i] & direction_select[i] & ~push[i] & (count[i] == 6'h01);
		end
	end

	// ------------------------------------------------------------
	// global registers
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			base_addr <= cmf_pkg::BASE_RESET;
			operating_mode_select <= cmf_pkg::MODE_RESET;
		end else if (access_wr && paddr == cmf_pkg::OFS_BASE_ADDR && config_mode) begin
			base_addr <= {pwdata[31:2], 2'b00};
		end else if (access_wr && paddr == cmf_pkg::OFS_MODE) begin
			operating_mode_select <= pwdata[2:0];
		end
	end

	// ------------------------------------------------------------
	// configuration fields
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			direction_select <= '0;
			auto_remote_reply_enable <= '0;
			for (int i = 0; i < N; i++) begin
				fifo_size[i] <= cmf_pkg::SIZE_RESET;
				transmit_priority[i] <= cmf_pkg::PRIO_LOWEST;
				irq_enable[i] <= '0;
			end
		end else begin
			for (int i = 0; i < N; i++) begin
				if (wr_ctrl[i]) begin
					direction_select[i] <= pwdata[cmf_pkg::CTL_DIR];
					auto_remote_reply_enable[i] <= pwdata[cmf_pkg::CTL_RTR_EN];
					transmit_priority[i] <= pwdata[cmf_pkg::CTL_PRIO_LSB +: 2];
					if (config_mode) begin
						fifo_size[i] <= pwdata[cmf_pkg::CTL_SIZE_LSB +: 5];
					end
				end
				if (wr_int[i]) begin
					irq_enable[i] <= {pwdata[cmf_pkg::INT_TX_IE_LSB +: 3],
						pwdata[cmf_pkg::INT_RX_IE_LSB +: 4]};
				end
			end
		end
	end

	// ------------------------------------------------------------
	// send request and abort
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			send_request <= '0;
			abort_pend <= '0;
		end else begin
			for (int i = 0; i < N; i++) begin
				if (fifo_rst[i]) begin
					send_request[i] <= 1'b0;
					abort_pend[i] <= 1'b0;
				end else if (wr_ctrl[i] && direction_select[i]) begin
					send_request[i] <= pwdata[cmf_pkg::CTL_SEND_REQ] |
						(hit[i] & eng_rtr_rx & auto_remote_reply_enable[i]);
					if (!pwdata[cmf_pkg::CTL_SEND_REQ] && send_request[i]) begin
						abort_pend[i] <= 1'b1;
					end
				end else if (hit[i] && eng_rtr_rx && auto_remote_reply_enable[i]) begin
					send_request[i] <= 1'b1;
				end else if (last_sent[i] || (hit[i] && eng_tx_aborted)) begin
					send_request[i] <= 1'b0;
					abort_pend[i] <= 1'b0;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// transmit outcome flags
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			msg_aborted_flag <= '0;
			lost_arbitration_flag <= '0;
			transmit_bus_error_flag <= '0;
		end else begin
			for (int i = 0; i < N; i++) begin
				if (fifo_rst[i]) begin
					msg_aborted_flag[i] <= 1'b0;
				end else if (hit[i] && eng_tx_aborted) begin
					msg_aborted_flag[i] <= 1'b1;
				end else if (hit[i] && eng_tx_done) begin
					msg_aborted_flag[i] <= 1'b0;
				end
				if (fifo_rst[i]) begin
					lost_arbitration_flag[i] <= 1'b0;
				end else if (hit[i] && eng_lost_arb) begin
					lost_arbitration_flag[i] <= 1'b1;
				end else if (rd_ctrl[i]) begin
					lost_arbitration_flag[i] <= 1'b0;
				end
				if (fifo_rst[i]) begin
					transmit_bus_error_flag[i] <= 1'b0;
				end else if (hit[i] && eng_bus_err) begin
					transmit_bus_error_flag[i] <= 1'b1;
				end else if (rd_ctrl[i]) begin
					transmit_bus_error_flag[i] <= 1'b0;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// overflow flag: set wins over a software clear
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_overflow_flag <= '0;
		end else begin
			for (int i = 0; i < N; i++) begin
				if (fifo_rst[i]) begin
					rx_overflow_flag[i] <= 1'b0;
				end else if (!direction_select[i] && hit[i] && eng_rx_store && flags[i][2]) begin
					rx_overflow_flag[i] <= 1'b1;
				end else if (wr_int[i] && !pwdata[cmf_pkg::INT_OVF_BIT]) begin
					rx_overflow_flag[i] <= 1'b0;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// head, tail and occupancy
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < N; i++) begin
				head[i] <= '0;
				tail[i] <= '0;
				count[i] <= '0;
			end
		end else begin
			for (int i = 0; i < N; i++) begin
				if (fifo_rst[i]) begin
					head[i] <= '0;
					tail[i] <= '0;
					count[i] <= '0;
				end else begin
					if (push[i]) begin
						head[i] <= next_ptr(head[i], fifo_size[i]);
					end
					if (pop[i]) begin
						tail[i] <= next_ptr(tail[i], fifo_size[i]);
					end
					count[i] <= count[i] + {5'h00, push[i]} - {5'h00, pop[i]};
				end
			end
		end
	end

	// ------------------------------------------------------------
	// read data, captured in the setup cycle
	// ------------------------------------------------------------
	logic [cmf_pkg::PTR_W-1:0] user_ptr [N];
	logic [cmf_pkg::PTR_W-1:0] bus_ptr [N];

	always_comb begin
		for (int i = 0; i < N; i++) begin
			user_ptr[i] = direction_select[i] ? head[i] : tail[i];
			bus_ptr[i] = direction_select[i] ? tail[i] : head[i];
		end
	end

	logic [31:0] next_prdata;

	always_comb begin
		next_prdata = 32'h0000_0000;
		if (paddr == cmf_pkg::OFS_BASE_ADDR) begin
			next_prdata = base_addr;
		end else if (paddr == cmf_pkg::OFS_MODE) begin
			next_prdata = {29'h0, operating_mode_select};
		end else if (in_region) begin
			case (acc_sub)
				cmf_pkg::SUB_CONTROL: begin
					next_prdata[cmf_pkg::CTL_SIZE_LSB +: 5] = fifo_size[acc_fifo];
					next_prdata[cmf_pkg::CTL_DIR] = direction_select[acc_fifo];
					next_prdata[cmf_pkg::CTL_ABORTED] = msg_aborted_flag[acc_fifo];
					next_prdata[cmf_pkg::CTL_LOST_ARB] = lost_arbitration_flag[acc_fifo];
					next_prdata[cmf_pkg::CTL_BUS_ERR] = transmit_bus_error_flag[acc_fifo];
					next_prdata[cmf_pkg::CTL_SEND_REQ] = send_request[acc_fifo];
					next_prdata[cmf_pkg::CTL_RTR_EN] = auto_remote_reply_enable[acc_fifo];
					next_prdata[cmf_pkg::CTL_PRIO_LSB +: 2] = transmit_priority[acc_fifo];
				end
				cmf_pkg::SUB_INT: begin
					next_prdata[cmf_pkg::INT_TX_IE_LSB +: 3] = irq_enable[acc_fifo][6:4];
					next_prdata[cmf_pkg::INT_RX_IE_LSB +: 4] = irq_enable[acc_fifo][3:0];
					next_prdata[cmf_pkg::INT_TX_IF_LSB +: 3] = flags[acc_fifo][6:4];
					next_prdata[cmf_pkg::INT_RX_IF_LSB +: 4] = flags[acc_fifo][3:0];
				end
				cmf_pkg::SUB_USER_ADDR: begin
					next_prdata = slot_addr(base_addr, acc_fifo, user_ptr[acc_fifo]);
				end
				cmf_pkg::SUB_BUS_INDEX: begin
					next_prdata[cmf_pkg::PTR_W-1:0] = bus_ptr[acc_fifo];
				end
				default: begin
					next_prdata = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (setup_rd) begin
			prdata <= next_prdata;
		end
	end

	// ------------------------------------------------------------
	// engine view and requests
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			eng_msg_index <= '0;
			eng_priority <= cmf_pkg::PRIO_LOWEST;
			eng_msg_addr <= '0;
		end else begin
			eng_msg_index <= bus_ptr[eng_fifo_sel];
			eng_priority <= transmit_priority[eng_fifo_sel];
			eng_msg_addr <= slot_addr(base_addr, eng_fifo_sel, bus_ptr[eng_fifo_sel]);
		end
	end

	always_comb begin
		for (int i = 0; i < N; i++) begin
			tx_request[i] = send_request[i] & direction_select[i];
			abort_request[i] = abort_pend[i] & direction_select[i];
			fifo_irq[i] = |(flags[i] & irq_enable[i]);
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_abort_flag_set: assert property (
		eng_tx_aborted && !fifo_rst[eng_fifo_sel] |=> msg_aborted_flag[$past(eng_fifo_sel)])
		else $error("aborted flag not set after abort");
	chk_lost_arb_set: assert property (
		eng_lost_arb && !fifo_rst[eng_fifo_sel] |=> lost_arbitration_flag[$past(eng_fifo_sel)])
		else $error("lost arbitration flag not set");
	chk_bus_err_set: assert property (
		eng_bus_err && !fifo_rst[eng_fifo_sel] |=> transmit_bus_error_flag[$past(eng_fifo_sel)])
		else $error("transmit error flag not set");
	chk_read_clears_flag: assert property (
		rd_ctrl[0] && !(hit[0] && (eng_lost_arb || eng_bus_err))
		|=> !lost_arbitration_flag[0] && !transmit_bus_error_flag[0])
		else $error("error flags survived a control read");
	chk_rx_ignores_send: assert property (
		wr_ctrl[0] && !direction_select[0] && !fifo_rst[0] && !(hit[0] && eng_rtr_rx)
		|=> $stable(send_request[0]))
		else $error("send request changed in receive fifo");
	chk_abort_request: assert property (
		wr_ctrl[0] && direction_select[0] && send_request[0] && !fifo_rst[0]
		&& !pwdata[cmf_pkg::CTL_SEND_REQ] |=> abort_request[0] || !direction_select[0])
		else $error("abort not requested after clearing send request");
	chk_rtr_reply: assert property (
		eng_rtr_rx && hit[0] && !auto_remote_reply_enable[0] && !wr_ctrl[0]
		&& !last_sent[0] && !eng_tx_aborted |=> $stable(send_request[0]))
		else $error("remote frame changed send request while reply disabled");
	chk_overflow_set: assert property (
		eng_rx_store && !direction_select[eng_fifo_sel] && flags[eng_fifo_sel][2]
		&& !fifo_rst[eng_fifo_sel] |=> rx_overflow_flag[$past(eng_fifo_sel)])
		else $error("overflow flag not set on store into full fifo");
	chk_send_self_clear: assert property (
		last_sent[0] && !wr_ctrl[0] && !(hit[0] && eng_rtr_rx) |=> !send_request[0])
		else $error("send request did not clear after last message");
endmodule // cmf_fifo_status
`default_nettype wire

// >>> tb/cmf_engine_model.sv
// protocol engine model that turns bench requests into engine event pulses
`timescale 1ns/1ps
`default_nettype none
module cmf_engine_model (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// bench request: 0 done, 1 abort, 2 arb, 3 err, 4 store, 5 remote
	input wire logic [5:0] ev_req,
	input wire logic [3:0] ev_sel,
	input wire logic [15:0] tx_request,
	// engine side of the block
	output logic [3:0] eng_fifo_sel,
	output logic [5:0] eng_ev
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			eng_ev <= 6'h00;
			eng_fifo_sel <= 4'h0;
		end else begin
			// a message is only sent while its fifo requests sending
			eng_ev <= {ev_req[5:1], ev_req[0] & tx_request[ev_sel]};
			eng_fifo_sel <= ev_sel;
		end
	end
endmodule // cmf_engine_model
`default_nettype wire

// >>> tb/test_can_message_fifo_status.sv
// self-checking bench for the fifo control and status block
`timescale 1ns/1ps
`default_nettype none
module test_can_message_fifo_status;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rdata, eng_msg_addr;
	logic [4:0] eng_msg_index;
	logic [5:0] ev_req = 6'h00, eng_ev;
	logic [3:0] ev_sel = 4'h0, eng_fifo_sel;
	logic [1:0] eng_priority;
	logic [15:0] tx_request, abort_request, fifo_irq;
	int failures = 0, samples_checked = 0;
	always #2.5 pclk = ~pclk;
	cmf_fifo_status DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .eng_fifo_sel(eng_fifo_sel), .eng_tx_done(eng_ev[0]),
		.eng_tx_aborted(eng_ev[1]), .eng_lost_arb(eng_ev[2]), .eng_bus_err(eng_ev[3]),
		.eng_rx_store(eng_ev[4]), .eng_rtr_rx(eng_ev[5]), .eng_msg_index(eng_msg_index),
		.eng_priority(eng_priority), .eng_msg_addr(eng_msg_addr), .tx_request(tx_request),
		.abort_request(abort_request), .fifo_irq(fifo_irq));
	cmf_engine_model partner (.pclk(pclk), .presetn(presetn), .ev_req(ev_req), .ev_sel(ev_sel),
		.tx_request(tx_request), .eng_fifo_sel(eng_fifo_sel), .eng_ev(eng_ev));
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	function automatic logic [11:0] ra(input int f, input int r);
		return 12'(32'h100 + f * 16 + r * 4);
	endfunction
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rdata = pslverr ? 32'hffff_ffff : prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			failures++;
			end_of_test();
		end
	endtask
	task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(nm, rdata, exp);
	endtask
	task automatic ev(input int k, input logic [3:0] f);
		ev_sel <= f;
		ev_req <= 6'(1 << k);
		@(posedge pclk);
		ev_req <= 6'h00;
		@(posedge pclk);
		#1;
	endtask
	task automatic settle();
		@(posedge pclk);
		#1;
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic s_reset_config();
		rd("ctl0", ra(0, 0), 32'h0);
		rd("int0", ra(0, 1), 32'h0);
		rd("ci0", ra(0, 3), 32'h0);
		rd("unmapped", 12'h0fc, 32'hffff_ffff);
		apb(1'b1, ra(0, 0), 32'h0003_0083);
		apb(1'b1, ra(1, 0), 32'h0001_0000);
		apb(1'b1, 12'h004, 32'h0);
		rd("ctl0 cfg", ra(0, 0), 32'h0003_0083);
		chk("prio", eng_priority, 32'h3);
	endtask
	task automatic s_tx_fill();
		rd("tx empty", ra(0, 1), 32'h700);
		apb(1'b1, ra(0, 0), 32'h2083);
		apb(1'b1, ra(0, 0), 32'h2083);
		apb(1'b1, ra(0, 1), 32'h0);
		rd("tx half", ra(0, 1), 32'h600);
		rd("ua head", ra(0, 2), 32'h20);
		apb(1'b1, ra(0, 0), 32'h2083);
		apb(1'b1, ra(0, 0), 32'h2083);
		apb(1'b1, ra(0, 0), 32'h2083);
		rd("tx full", ra(0, 1), 32'h0);
		rd("ua full", ra(0, 2), 32'h0);
	endtask
	task automatic s_send();
		apb(1'b1, ra(0, 0), 32'h8b);
		settle();
		chk("send_request", tx_request[0], 32'h1);
		ev(0, 4'h0);
		rd("ci tx", ra(0, 3), 32'h1);
		chk("eng idx tx", eng_msg_index, 32'h1);
		chk("eng addr tx", eng_msg_addr, 32'h10);
		rd("tx 3", ra(0, 1), 32'h400);
		for (int i = 0; i < 3; i++)
			ev(0, 4'h0);
		rd("sent", ra(0, 0), 32'h0003_0083);
		chk("send_request off", tx_request[0], 32'h0);
	endtask
	task automatic s_errors_abort();
		ev(2, 4'h0);
		ev(3, 4'h0);
		rd("errs", ra(0, 0), 32'h0003_00b3);
		rd("errs clr", ra(0, 0), 32'h0003_0083);
		apb(1'b1, ra(0, 0), 32'h2083);
		apb(1'b1, ra(0, 0), 32'h8b);
		apb(1'b1, ra(0, 0), 32'h83);
		settle();
		chk("abort req", abort_request[0], 32'h1);
		ev(1, 4'h0);
		chk("abort done", abort_request[0], 32'h0);
		rd("aborted", ra(0, 0), 32'h0003_00c3);
		apb(1'b1, ra(0, 0), 32'h8b);
		ev(0, 4'h0);
		rd("completed", ra(0, 0), 32'h0003_0083);
		ev(5, 4'h0);
		rd("rtr off", ra(0, 0), 32'h0003_0083);
		apb(1'b1, ra(0, 0), 32'h87);
		ev(5, 4'h0);
		rd("rtr on", ra(0, 0), 32'h0003_008f);
		apb(1'b1, ra(0, 0), 32'h2083);
		ev(2, 4'h0);
		ev(1, 4'h0);
		apb(1'b1, ra(0, 0), 32'h4083);
		rd("rst ctl", ra(0, 0), 32'h0003_0083);
		rd("rst int", ra(0, 1), 32'h700);
	endtask
	task automatic s_rx();
		apb(1'b1, ra(1, 1), 32'h0001_0000);
		settle();
		chk("irq idle", fifo_irq[1], 32'h0);
		ev(4, 4'h1);
		rd("rx one", ra(1, 1), 32'h0001_0003);
		chk("irq on", fifo_irq[1], 32'h1);
		rd("ci rx", ra(1, 3), 32'h1);
		chk("eng idx rx", eng_msg_index, 32'h1);
		chk("eng addr rx", eng_msg_addr, 32'h210);
		ev(4, 4'h1);
		rd("rx full", ra(1, 1), 32'h0001_0007);
		ev(4, 4'h1);
		rd("rx ovf", ra(1, 1), 32'h0001_000f);
		apb(1'b1, ra(1, 0), 32'h2008);
		settle();
		chk("rx send_request", tx_request[1], 32'h0);
		rd("rx ctl", ra(1, 0), 32'h0001_0000);
		rd("ua tail", ra(1, 2), 32'h210);
		apb(1'b1, ra(1, 1), 32'h0);
		rd("rx clr", ra(1, 1), 32'h3);
		chk("irq off", fifo_irq[1], 32'h0);
	endtask
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		s_reset_config();
		s_tx_fill();
		s_send();
		s_errors_abort();
		s_rx();
		end_of_test();
	end
endmodule // test_can_message_fifo_status
`default_nettype wire
